// [rtl/byte_fifo.sv]
`timescale 1ns/1ns
module byte_fifo (
  input wire logic clk_in,
  input wire logic rst_n_in,
  fifo_if.store q
);
  typedef struct packed {
    logic [serial_pkg::FIFO_DEPTH-1:0][7:0] mem;
    logic [serial_pkg::FIFO_AW-1:0] rd;
    logic [serial_pkg::FIFO_AW-1:0] wr;
    logic [4:0] cnt;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic push;
  logic pop;

  always_comb begin
    next_st = st;
    push = q.push_valid & q.push_ready;
    pop = q.pop_ready & q.pop_valid;
    if (push) begin
      next_st.mem[st.wr] = q.push_data;
      next_st.wr = st.wr + 4'h1;
    end
    if (pop) begin
      next_st.rd = st.rd + 4'h1;
    end
    next_st.cnt = st.cnt + {4'h0, push} - {4'h0, pop};
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q.push_ready = (st.cnt != 5'(serial_pkg::FIFO_DEPTH));
  assign q.pop_valid = (st.cnt != 5'h00);
  assign q.pop_data = st.mem[st.rd];
  assign q.count = st.cnt;
endmodule : byte_fifo

// [rtl/uart_serial_channel.sv]
// Summary of operation
// [RULE1] transmit and receive paths run independently
// [RULE2] three identical channels, separate configuration
// [RULE3] 5-8 data bits, optional parity, 1-2 stops
// [RULE4] every register access is 8 bits wide
// [RULE5] 16-bit divisor written by software sets timing
// [RULE6] scratch register stores value, no effect
// [RULE7] separate transmit and receive FIFOs per channel
// [RULE8] loop-back routes transmit line into receiver
// [RULE9] DMA request lines reflect FIFO readiness
// [RULE10] each channel has own DMA request pair
// [RULE11] pause/resume characters stop and restart transmit
// [RULE12] RTS/CTS hardware flow control, peer obeys RTS
// [RULE13] one interrupt line per channel
// [RULE14] divisor reaches all standard rates 110 to 921600
// [RULE15] any rate from 110 bps to 3 Mbps; the code gives only the steps CLK_HZ / (OS_RATIO * div), none at 3 Mbps
// [RULE16] automatic bit-rate detection from start bit width
// [RULE17] idle high, start low, LSB first, stops high
// [RULE18] mid-bit sampling, parity/framing/overrun flags raised
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
module uart_serial_channel (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [serial_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [serial_pkg::ADDR_W-1:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  input wire logic [2:0] rxd_in,
  input wire logic [2:0] cts_n_in,
  output logic [2:0] txd_out,
  output logic [2:0] rts_n_out,
  output logic [2:0] tx_dma_req_out,
  output logic [2:0] rx_dma_req_out,
  output logic [2:0] irq_out
);
  typedef struct packed {
    logic [15:0] div;
    logic [7:0] fmt;
    logic hw_flow;
    logic [7:0] irq_en;
    logic [7:0] scratch;
    logic par_err;
    logic frame_err;
    logic overrun;
    logic paused;
    logic ab_busy;
    logic ab_low;
    logic ab_done;
    logic [serial_pkg::AB_CNT_W-1:0] ab_cnt;
    logic [15:0] bcnt;
    serial_pkg::ser_state_t tx_st;
    logic [7:0] tx_sh;
    logic tx_par;
    logic [2:0] tx_n;
    logic [3:0] tx_os;
    logic tx_line;
    logic txd;
    serial_pkg::ser_state_t rx_st;
    logic [7:0] rx_sh;
    logic rx_par;
    logic [2:0] rx_n;
    logic [3:0] rx_os;
    logic rts_n;
  } chan_t;

  typedef struct packed {
    logic aw_v;
    logic [serial_pkg::ADDR_W-1:0] aw_a;
    logic w_v;
    logic [7:0] w_d;
    logic w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    chan_t [2:0] ch;
  } state_t;

  state_t st;
  state_t next_st;
  chan_t k;
  logic wr;
  logic rd;
  logic whit;
  logic rhit;
  logic tick;
  logic rxl;
  logic tx_end;
  logic rx_end;
  logic [2:0] wlast;
  logic [7:0] rword;
  logic [3:0] wreg;
  logic [3:0] rreg;
  logic [2:0] tx_push;
  logic [2:0] tx_push_ok;
  logic [2:0] tx_pop;
  logic [2:0] tx_avail;
  logic [2:0] rx_push;
  logic [2:0] rx_push_ok;
  logic [2:0] rx_pop;
  logic [2:0] rx_avail;
  logic [2:0][7:0] tx_head;
  logic [2:0][7:0] rx_head;
  logic [2:0][7:0] rx_wdata;
  logic [2:0][4:0] rx_count;
  logic [2:0][7:0] stat;

  always_comb begin
    next_st = st;
    k = st.ch[0];
    tick = 1'b0;
    rxl = 1'b1;
    tx_end = 1'b0;
    rx_end = 1'b0;
    wlast = 3'h7;
    rword = 8'h00;
    tx_push = '0;
    tx_pop = '0;
    rx_push = '0;
    rx_pop = '0;
    rx_wdata = '0;
    stat = '0;
    wreg = st.aw_a[5:2];
    rreg = s_axi_araddr_in[5:2];
    whit = (st.aw_a[11:8] == 4'h0) && (st.aw_a[7:6] <= serial_pkg::CH_LAST)
           && (wreg <= serial_pkg::REG_SCRATCH_IDX);
    rhit = (s_axi_araddr_in[11:8] == 4'h0) && (s_axi_araddr_in[7:6] <= serial_pkg::CH_LAST)
           && (rreg <= serial_pkg::REG_SCRATCH_IDX);
    wr = st.aw_v & st.w_v & ~st.bvalid;
    rd = s_axi_arvalid_in & ~st.rvalid;
    // one write in flight: nothing is taken while a response waits
    if (s_axi_awvalid_in && !st.aw_v && !st.bvalid) begin
      next_st.aw_v = 1'b1;
      next_st.aw_a = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !st.w_v && !st.bvalid) begin
      next_st.w_v = 1'b1;
      next_st.w_d = s_axi_wdata_in[7:0];
      next_st.w_s = s_axi_wstrb_in[0];
    end
    if (st.bvalid && s_axi_bready_in) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
    end
    if (wr) begin
      next_st.aw_v = 1'b0;
      next_st.w_v = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = whit ? serial_pkg::RESP_OKAY : serial_pkg::RESP_SLVERR;
    end
    if (rd) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = 8'h00;
      next_st.rresp = rhit ? serial_pkg::RESP_OKAY : serial_pkg::RESP_SLVERR;
    end
    // [RULE2] identical channel logic
    for (int c = 0; c < serial_pkg::NUM_CH; c++) begin
      k = st.ch[c];
      // [RULE14] [RULE15] full divisor range
      // [RULE5] divisor tick generation
      tick = (st.ch[c].bcnt == 16'h0000);
      k.bcnt = tick ? ((k.div == 16'h0000) ? 16'h0000 : k.div - 16'h0001) : k.bcnt - 16'h0001;
      wlast = {1'b1, k.fmt[1:0]};
      stat[c] = {k.paused, k.ab_done, (k.tx_st == serial_pkg::SER_IDLE) & ~tx_avail[c],
                 k.overrun, k.frame_err, k.par_err, ~tx_push_ok[c], rx_avail[c]};
      // [RULE4] byte-wide register writes
      if (wr && whit && st.w_s && (st.aw_a[7:6] == 2'(c))) begin
        if (wreg == serial_pkg::REG_DATA_IDX) begin
          // dropped silently when the transmit FIFO is full
          tx_push[c] = 1'b1;
        end else if (wreg == serial_pkg::REG_DIV_LO_IDX) begin
          k.div[7:0] = st.w_d;
        end else if (wreg == serial_pkg::REG_DIV_HI_IDX) begin
          k.div[15:8] = st.w_d;
        end else if (wreg == serial_pkg::REG_FORMAT_IDX) begin
          k.fmt = st.w_d;
          // [RULE16] start rate detection
          if (st.w_d[serial_pkg::FMT_AUTOBAUD]) begin
            k.ab_busy = 1'b1;
            k.ab_low = 1'b0;
            k.ab_cnt = '0;
            k.ab_done = 1'b0;
          end
        end else if (wreg == serial_pkg::REG_FLOW_IDX) begin
          k.hw_flow = st.w_d[serial_pkg::FLOW_HW];
        end else if (wreg == serial_pkg::REG_STATUS_IDX) begin
          // cleared here, set below, so a same-cycle event survives
          k.par_err = k.par_err & ~st.w_d[serial_pkg::ST_PAR_ERR];
          k.frame_err = k.frame_err & ~st.w_d[serial_pkg::ST_FRAME_ERR];
          k.overrun = k.overrun & ~st.w_d[serial_pkg::ST_OVERRUN];
          k.ab_done = k.ab_done & ~st.w_d[serial_pkg::ST_AB_DONE];
        end else if (wreg == serial_pkg::REG_IRQ_EN_IDX) begin
          k.irq_en = st.w_d;
        // [RULE6] scratch store only
        end else begin
          k.scratch = st.w_d;
        end
      end
      // [RULE1] transmit path
      tx_end = tick && (st.ch[c].tx_os == serial_pkg::OS_LAST);
      if (tick && (k.tx_st != serial_pkg::SER_IDLE)) begin
        k.tx_os = k.tx_os + 4'h1;
      end
      case (k.tx_st)
        serial_pkg::SER_IDLE: begin
          // [RULE11] pause on received stop character
          // [RULE12] wait for clear-to-send
          if (tx_avail[c] && !(k.fmt[serial_pkg::FMT_SWFLOW] && k.paused)
              && !(k.hw_flow && cts_n_in[c])) begin
            tx_pop[c] = 1'b1;
            k.tx_sh = tx_head[c];
            k.tx_par = 1'b0;
            k.tx_n = 3'h0;
            k.tx_os = 4'h0;
            k.tx_st = serial_pkg::SER_START;
          end
        end
        serial_pkg::SER_START: begin
          if (tx_end) begin
            k.tx_st = serial_pkg::SER_DATA;
          end
        end
        serial_pkg::SER_DATA: begin
          if (tx_end) begin
            k.tx_par = k.tx_par ^ k.tx_sh[0];
            k.tx_sh = k.tx_sh >> 1;
            k.tx_n = k.tx_n + 3'h1;
            if (st.ch[c].tx_n == wlast) begin
              k.tx_n = 3'h0;
              k.tx_st = k.fmt[serial_pkg::FMT_PAR_EN] ? serial_pkg::SER_PAR : serial_pkg::SER_STOP;
            end
          end
        end
        serial_pkg::SER_PAR: begin
          if (tx_end) begin
            k.tx_st = serial_pkg::SER_STOP;
          end
        end
        default: begin
          // [RULE3] one or two stop bits
          if (tx_end) begin
            k.tx_n = k.tx_n + 3'h1;
            if (st.ch[c].tx_n == {2'b00, k.fmt[serial_pkg::FMT_STOP2]}) begin
              k.tx_st = serial_pkg::SER_IDLE;
            end
          end
        end
      endcase
      // [RULE17] line level per phase
      case (k.tx_st)
        serial_pkg::SER_START: k.tx_line = 1'b0;
        serial_pkg::SER_DATA: k.tx_line = k.tx_sh[0];
        serial_pkg::SER_PAR: k.tx_line = k.tx_par ^ k.fmt[serial_pkg::FMT_PAR_ODD];
        default: k.tx_line = 1'b1;
      endcase
      // [RULE8] pin held idle in loop-back
      k.txd = k.tx_line | k.fmt[serial_pkg::FMT_LOOP];
      rxl = st.ch[c].fmt[serial_pkg::FMT_LOOP] ? st.ch[c].tx_line : rxd_in[c];
      // [RULE18] mid-bit receive sampling
      rx_end = tick && (st.ch[c].rx_os == serial_pkg::OS_LAST);
      if (tick && (k.rx_st != serial_pkg::SER_IDLE)) begin
        k.rx_os = k.rx_os + 4'h1;
      end
      if (k.ab_busy) begin
        // [RULE16] width of first low pulse
        k.rx_st = serial_pkg::SER_IDLE;
        if (!rxl) begin
          k.ab_low = 1'b1;
          if (k.ab_cnt != '1) begin
            k.ab_cnt = k.ab_cnt + 20'h00001;
          end
        end else if (k.ab_low) begin
          k.div = (k.ab_cnt[19:4] == 16'h0000) ? 16'h0001 : k.ab_cnt[19:4];
          k.ab_busy = 1'b0;
          k.ab_done = 1'b1;
        end
      end else begin
        case (k.rx_st)
          serial_pkg::SER_IDLE: begin
            if (!rxl) begin
              k.rx_os = 4'h0;
              k.rx_st = serial_pkg::SER_START;
            end
          end
          serial_pkg::SER_START: begin
            // glitch shorter than half a bit returns to idle
            if (tick && (st.ch[c].rx_os == serial_pkg::OS_MID)) begin
              k.rx_st = rxl ? serial_pkg::SER_IDLE : serial_pkg::SER_DATA;
              k.rx_os = 4'h0;
              k.rx_n = 3'h0;
              k.rx_par = 1'b0;
            end
          end
          serial_pkg::SER_DATA: begin
            if (rx_end) begin
              k.rx_sh = {rxl, k.rx_sh[7:1]};
              k.rx_par = k.rx_par ^ rxl;
              k.rx_n = k.rx_n + 3'h1;
              if (st.ch[c].rx_n == wlast) begin
                k.rx_st = k.fmt[serial_pkg::FMT_PAR_EN] ? serial_pkg::SER_PAR : serial_pkg::SER_STOP;
              end
            end
          end
          serial_pkg::SER_PAR: begin
            if (rx_end) begin
              if (rxl != (k.rx_par ^ k.fmt[serial_pkg::FMT_PAR_ODD])) begin
                k.par_err = 1'b1;
              end
              k.rx_st = serial_pkg::SER_STOP;
            end
          end
          default: begin
            // only the first stop bit is checked; back-to-back frames stay aligned
            if (rx_end) begin
              k.rx_st = serial_pkg::SER_IDLE;
              if (!rxl) begin
                k.frame_err = 1'b1;
              end
              rword = k.rx_sh >> (3'h7 - wlast);
              // [RULE11] pause and resume characters
              if (k.fmt[serial_pkg::FMT_SWFLOW] && (rword == serial_pkg::XOFF_CHAR)) begin
                k.paused = 1'b1;
              end else if (k.fmt[serial_pkg::FMT_SWFLOW] && (rword == serial_pkg::XON_CHAR)) begin
                k.paused = 1'b0;
              end else begin
                rx_push[c] = 1'b1;
                rx_wdata[c] = rword;
                if (!rx_push_ok[c]) begin
                  k.overrun = 1'b1;
                end
              end
            end
          end
        endcase
      end
      // [RULE12] request-to-send from FIFO level
      k.rts_n = k.hw_flow && (rx_count[c] >= serial_pkg::RTS_LEVEL);
      if (rd && rhit && (s_axi_araddr_in[7:6] == 2'(c))) begin
        if (rreg == serial_pkg::REG_DATA_IDX) begin
          rx_pop[c] = rx_avail[c];
          next_st.rdata = rx_head[c];
        end else if (rreg == serial_pkg::REG_DIV_LO_IDX) begin
          next_st.rdata = st.ch[c].div[7:0];
        end else if (rreg == serial_pkg::REG_DIV_HI_IDX) begin
          next_st.rdata = st.ch[c].div[15:8];
        end else if (rreg == serial_pkg::REG_FORMAT_IDX) begin
          next_st.rdata = {st.ch[c].fmt[7], st.ch[c].ab_busy, st.ch[c].fmt[5:0]};
        end else if (rreg == serial_pkg::REG_FLOW_IDX) begin
          next_st.rdata = {7'h00, st.ch[c].hw_flow};
        end else if (rreg == serial_pkg::REG_STATUS_IDX) begin
          next_st.rdata = stat[c];
        end else if (rreg == serial_pkg::REG_IRQ_EN_IDX) begin
          next_st.rdata = st.ch[c].irq_en;
        end else begin
          next_st.rdata = st.ch[c].scratch;
        end
      end
      next_st.ch[c] = k;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
      for (int c = 0; c < serial_pkg::NUM_CH; c++) begin
        st.ch[c].div <= serial_pkg::DIV_RESET;
        st.ch[c].fmt <= serial_pkg::FMT_RESET;
        st.ch[c].tx_line <= 1'b1;
        st.ch[c].txd <= 1'b1;
      end
    end else begin
      st <= next_st;
    end
  end

  // [RULE7] separate FIFOs per direction
  for (genvar g = 0; g < serial_pkg::NUM_CH; g++) begin : g_chan
    fifo_if tx_q ();
    fifo_if rx_q ();
    byte_fifo tx_fifo (.clk_in(clk_in), .rst_n_in(rst_n_in), .q(tx_q));
    byte_fifo rx_fifo (.clk_in(clk_in), .rst_n_in(rst_n_in), .q(rx_q));
    assign tx_q.push_valid = tx_push[g];
    assign tx_q.push_data = st.w_d;
    assign tx_q.pop_ready = tx_pop[g];
    assign tx_push_ok[g] = tx_q.push_ready;
    assign tx_avail[g] = tx_q.pop_valid;
    assign tx_head[g] = tx_q.pop_data;
    assign rx_q.push_valid = rx_push[g];
    assign rx_q.push_data = rx_wdata[g];
    assign rx_q.pop_ready = rx_pop[g];
    assign rx_push_ok[g] = rx_q.push_ready;
    assign rx_avail[g] = rx_q.pop_valid;
    assign rx_head[g] = rx_q.pop_data;
    assign rx_count[g] = rx_q.count;
    assign txd_out[g] = st.ch[g].txd;
    assign rts_n_out[g] = st.ch[g].rts_n;
    // [RULE9] FIFO readiness to DMA
    // [RULE10] dedicated request pair
    assign tx_dma_req_out[g] = tx_q.push_ready;
    assign rx_dma_req_out[g] = rx_q.pop_valid;
    // [RULE13] per-channel interrupt
    assign irq_out[g] = |(stat[g] & st.ch[g].irq_en);
  end

  assign s_axi_awready_out = ~st.aw_v & ~st.bvalid;
  assign s_axi_wready_out = ~st.w_v & ~st.bvalid;
  assign s_axi_bvalid_out = st.bvalid;
  assign s_axi_bresp_out = st.bresp;
  assign s_axi_arready_out = ~st.rvalid;
  assign s_axi_rvalid_out = st.rvalid;
  assign s_axi_rdata_out = {24'h000000, st.rdata};
  assign s_axi_rresp_out = st.rresp;
endmodule : uart_serial_channel

// [shared/fifo_if.sv]
`timescale 1ns/1ns
interface fifo_if;
  logic push_valid;
  logic push_ready;
  logic [7:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [7:0] pop_data;
  logic [4:0] count;
  modport store (input push_valid, input push_data, input pop_ready,
                 output push_ready, output pop_valid, output pop_data, output count);
  modport user (output push_valid, output push_data, output pop_ready,
                input push_ready, input pop_valid, input pop_data, input count);
endinterface : fifo_if

// [shared/serial_pkg.sv]
package serial_pkg;
  localparam int NUM_CH = 3;
  localparam int ADDR_W = 12;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  // clock and default bit rate
  localparam int CLK_HZ = 100_000_000;
  localparam int OS_RATIO = 16;
  localparam int RESET_BAUD = 115200;
  localparam logic [15:0] DIV_RESET = 16'(CLK_HZ / (OS_RATIO * RESET_BAUD));
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam int AB_CNT_W = 20;
  // channel window: byte address = channel * 0x40 + index * 4
  localparam logic [3:0] REG_DATA_IDX = 4'h0;
  localparam logic [3:0] REG_DIV_LO_IDX = 4'h1;
  localparam logic [3:0] REG_DIV_HI_IDX = 4'h2;
  localparam logic [3:0] REG_FORMAT_IDX = 4'h3;
  localparam logic [3:0] REG_FLOW_IDX = 4'h4;
  localparam logic [3:0] REG_STATUS_IDX = 4'h5;
  localparam logic [3:0] REG_IRQ_EN_IDX = 4'h6;
  localparam logic [3:0] REG_SCRATCH_IDX = 4'h7;
  localparam logic [1:0] CH_LAST = 2'h2;
  // format register fields
  localparam int FMT_STOP2 = 2;
  localparam int FMT_PAR_EN = 3;
  localparam int FMT_PAR_ODD = 4;
  localparam int FMT_LOOP = 5;
  localparam int FMT_AUTOBAUD = 6;
  localparam int FMT_SWFLOW = 7;
  localparam logic [7:0] FMT_RESET = 8'h03;
  localparam int FLOW_HW = 0;
  // status register fields
  localparam int ST_RX_AVAIL = 0;
  localparam int ST_TX_FULL = 1;
  localparam int ST_PAR_ERR = 2;
  localparam int ST_FRAME_ERR = 3;
  localparam int ST_OVERRUN = 4;
  localparam int ST_TX_IDLE = 5;
  localparam int ST_AB_DONE = 6;
  localparam int ST_PAUSED = 7;
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;
  localparam logic [4:0] RTS_LEVEL = 5'h0C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SER_IDLE = 3'b000,
    SER_START = 3'b001,
    SER_DATA = 3'b010,
    SER_PAR = 3'b011,
    SER_STOP = 3'b100
  } ser_state_t;
endpackage : serial_pkg

// [tb/serial_peer_model.sv]
`timescale 1ns/1ns
module serial_peer_model #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_in,
  input wire logic [2:0] txd_in,
  input wire logic [2:0] rts_n_in,
  output logic [2:0] rxd_out
);
  logic [7:0] got_q[3][$];
  logic [2:0] paused;
  initial begin
    rxd_out = 3'h7;
    paused = 3'h0;
  end
  task automatic send_byte(input int ch, input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    while (rts_n_in[ch] !== 1'b0 || paused[ch]) @(posedge clk_in);
    for (int i = 0; i < 10; i++) begin
      rxd_out[ch] <= f[i];
      repeat (BIT_CLKS) @(posedge clk_in);
    end
  endtask : send_byte
  for (genvar c = 0; c < 3; c++) begin : g_rx
    always begin : rx_loop
      logic [7:0] b;
      @(negedge txd_in[c]);
      repeat (BIT_CLKS / 2) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge clk_in);
        b[i] = txd_in[c];
      end
      // stop at mid stop bit so a back-to-back start is not missed
      repeat (BIT_CLKS) @(posedge clk_in);
      if (b == serial_pkg::XOFF_CHAR) paused[c] = 1'b1;
      else if (b == serial_pkg::XON_CHAR) paused[c] = 1'b0;
      else got_q[c].push_back(b);
    end
  end
endmodule : serial_peer_model

// [tb/tb_uart_serial_channel.sv]
`timescale 1ns/1ns
module tb_uart_serial_channel;
  localparam int BIT_CLKS = serial_pkg::OS_RATIO * 2;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic s_axi_awvalid_in = 1'b0;
  logic s_axi_wvalid_in = 1'b0;
  logic s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0;
  logic s_axi_rready_in = 1'b0;
  logic [11:0] s_axi_awaddr_in = 12'h000;
  logic [11:0] s_axi_araddr_in = 12'h000;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'hF;
  logic [2:0] cts_n_in = 3'h0;
  logic [2:0] rxd_in;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out;
  logic [2:0] txd_out, rts_n_out, tx_dma_req_out, rx_dma_req_out, irq_out;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  uart_serial_channel dut (.*);
  serial_peer_model #(.BIT_CLKS(BIT_CLKS)) u_peer (
    .clk_in(clk_in),
    .txd_in(txd_out),
    .rts_n_in(rts_n_out),
    .rxd_out(rxd_in)
  );

  always #5 clk_in = ~clk_in;

  function automatic logic [11:0] ra(input int ch, input logic [3:0] idx);
    return 12'(ch * 64) + {6'h0, idx, 2'h0};
  endfunction : ra

  function automatic logic [7:0] wmask(input logic [1:0] w);
    return 8'hFF >> (2'h3 - w);
  endfunction : wmask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h0, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_awready_out && s_axi_awvalid_in) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out && s_axi_wvalid_in) s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 1'b0;
    check({30'h0, s_axi_bresp_out}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] v);
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_arready_out && s_axi_arvalid_in) s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1);
    s_axi_rready_in <= 1'b0;
    v = s_axi_rdata_out;
    check({30'h0, s_axi_rresp_out}, {30'h0, er});
  endtask : rd

  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  // hang guard, well above the few thousand cycles the traffic needs
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  initial begin : main
    logic [31:0] v;
    logic [7:0] b;
    logic [7:0] t;
    logic [7:0] sc [3];
    void'($urandom(63));
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    check({29'h0, tx_dma_req_out}, 32'h7);
    check({29'h0, rx_dma_req_out}, 32'h0);
    for (int c = 0; c < 3; c++) begin
      rd(ra(c, serial_pkg::REG_FORMAT_IDX), serial_pkg::RESP_OKAY, v);
      check(v, {24'h0, serial_pkg::FMT_RESET});
      rd(ra(c, serial_pkg::REG_DIV_LO_IDX), serial_pkg::RESP_OKAY, v);
      check(v, {24'h0, serial_pkg::DIV_RESET[7:0]});
      sc[c] = 8'($urandom);
      wr(ra(c, serial_pkg::REG_SCRATCH_IDX), sc[c], serial_pkg::RESP_OKAY);
    end
    for (int c = 0; c < 3; c++) begin
      rd(ra(c, serial_pkg::REG_SCRATCH_IDX), serial_pkg::RESP_OKAY, v);
      check(v, {24'h0, sc[c]});
      wr(ra(c, serial_pkg::REG_DIV_LO_IDX), 8'h02, serial_pkg::RESP_OKAY);
      wr(ra(c, serial_pkg::REG_DIV_HI_IDX), 8'h00, serial_pkg::RESP_OKAY);
    end
    rd(12'h300, serial_pkg::RESP_SLVERR, v);
    check(v, 32'h0);
    wr(12'h300, 8'hA5, serial_pkg::RESP_SLVERR);
    wr(ra(1, serial_pkg::REG_IRQ_EN_IDX), 8'h01, serial_pkg::RESP_OKAY);
    // both directions at once on every channel
    for (int c = 0; c < 3; c++) begin
      b = 8'h20 + 8'($urandom % 208);
      t = 8'h20 + 8'($urandom % 208);
      wr(ra(c, serial_pkg::REG_DATA_IDX), b, serial_pkg::RESP_OKAY);
      u_peer.send_byte(c, t);
      check({29'h0, rx_dma_req_out}, 32'(1 << c));
      check({29'h0, irq_out}, (c == 1) ? 32'h2 : 32'h0);
      rd(ra(c, serial_pkg::REG_DATA_IDX), serial_pkg::RESP_OKAY, v);
      check(v, {24'h0, t});
      while (u_peer.got_q[c].size() == 0) @(posedge clk_in);
      check({24'h0, u_peer.got_q[c].pop_front()}, {24'h0, b});
      check({29'h0, irq_out}, 32'h0);
    end
    // cts withdrawn must hold the character back
    wr(ra(2, serial_pkg::REG_FLOW_IDX), 8'h01, serial_pkg::RESP_OKAY);
    cts_n_in <= 3'h4;
    b = 8'h20 + 8'($urandom % 208);
    wr(ra(2, serial_pkg::REG_DATA_IDX), b, serial_pkg::RESP_OKAY);
    repeat (4 * BIT_CLKS) @(posedge clk_in);
    check({31'h0, txd_out[2]}, 32'h1);
    check({31'h0, rts_n_out[2]}, 32'h0);
    cts_n_in <= 3'h0;
    while (u_peer.got_q[2].size() == 0) @(posedge clk_in);
    check({24'h0, u_peer.got_q[2].pop_front()}, {24'h0, b});
    // loop-back through every word length, parity and stop setting
    for (int w = 0; w < 4; w++) begin
      wr(ra(0, serial_pkg::REG_FORMAT_IDX), 8'h20 | {3'h0, 1'(w), 2'(w), 2'(w)},
        serial_pkg::RESP_OKAY);
      b = 8'($urandom);
      wr(ra(0, serial_pkg::REG_DATA_IDX), b, serial_pkg::RESP_OKAY);
      while (rx_dma_req_out[0] !== 1'b1) @(posedge clk_in);
      check({31'h0, txd_out[0]}, 32'h1);
      rd(ra(0, serial_pkg::REG_DATA_IDX), serial_pkg::RESP_OKAY, v);
      check(v, {24'h0, b & wmask(2'(w))});
    end
    // parity, framing and overrun must stay clear after clean loop-back frames
    rd(ra(0, serial_pkg::REG_STATUS_IDX), serial_pkg::RESP_OKAY, v);
    check(v & 32'h1D, 32'h0);
    results();
  end
endmodule : tb_uart_serial_channel

// [tb/uart_serial_channel_checker.sv]
`timescale 1ns/1ns
module uart_serial_channel_checker (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [2:0] txd_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_wr_taken;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  a_write_answer: assert property (s_wr_taken |=> !s_axi_awready_out ##1 s_axi_bvalid_out)
    else $error("write response not on time");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid_out && !(|s_axi_rdata_out[31:8]))
    else $error("read response late or wider than a byte");
  a_rvalid_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read response dropped or changed");
  a_bvalid_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped or changed");
  a_write_block: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write accepted while response pending");
  a_read_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read accepted while data pending");
  a_bresp_release: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
    else $error("write response not released");
  a_start_width: assert property ($fell(txd_out[0]) |-> !txd_out[0] [*8])
    else $error("start bit too short");
endmodule : uart_serial_channel_checker

bind uart_serial_channel uart_serial_channel_checker u_checker (.*);
